// >>> include/rsk_pkg.sv
// Package holding the sizes, reset values and control polarities of the register stack.
package rsk_pkg;
  localparam int RSK_WORDS = 16;
  localparam int RSK_ADDR_W = 4;
  localparam int RSK_DATA_W = 4;
  localparam logic RSK_ACTIVE = 1'b0;
  localparam logic [RSK_DATA_W-1:0] RSK_OUT_RST = 4'h0;
  localparam logic [RSK_DATA_W-1:0] RSK_WORD_RST = 4'h0;
  typedef enum logic [1:0] {
    RSK_PH_LOW = 2'b01,
    RSK_PH_HIGH = 2'b10
  } rsk_phase_t;
endpackage

// >>> verilog/rsk_word_cell.sv
// One storage word of the register stack, written while its write strobe is asserted.
`timescale 1ns/1ps
`default_nettype none
module rsk_word_cell #(
  parameter int DATA_W = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Write side
  input wire logic wr_sel_i,
  input wire logic [DATA_W-1:0] write_data_i,
  // Stored word
  output logic [DATA_W-1:0] word_o
);
  import rsk_pkg::*;

  logic [DATA_W-1:0] word_reg;

  // The transparent write is sampled every clock, so the word follows data while selected.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      word_reg <= RSK_WORD_RST;
    end else if (wr_sel_i) begin
      word_reg <= write_data_i;
    end
  end

  assign word_o = word_reg;
endmodule // rsk_word_cell
`default_nettype wire

// >>> verilog/rsk_register_stack.sv
// Sixteen by four register stack with edge-loaded output register and three-state outputs.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Operation
// - The stack holds sixteen four-bit words chosen by a four-bit address.
// - A word is written while write enable, chip select and the pin clock are all low.
// - While those three stay low the addressed word follows the data input.
// - A rising pin clock with chip select low loads the addressed word into the output register.
// - The output register keeps its value while the array is written.
// - With output enable high the four data outputs float.
// - With output enable low the outputs drive the output register.
// - The output register changes only on the rising pin clock, never the falling one.
// - Chip select, output enable and write enable are active low.
module rsk_register_stack #(
  parameter int WORDS = rsk_pkg::RSK_WORDS,
  parameter int ADDR_W = rsk_pkg::RSK_ADDR_W,
  parameter int DATA_W = rsk_pkg::RSK_DATA_W
) (
  // System clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host strobes; all but out_en_n_i are sampled on mclk_i
  input wire logic clock_pulse_in_i,
  input wire logic chip_sel_n_i,
  input wire logic write_en_n_i,
  input wire logic out_en_n_i,
  // Address and data
  input wire logic [ADDR_W-1:0] word_addr_i,
  input wire logic [DATA_W-1:0] write_data_i,
  // Three-state data outputs
  output logic [DATA_W-1:0] read_data_out_o,
  output logic [DATA_W-1:0] read_data_out_oe_o
);
  import rsk_pkg::*;

  logic [DATA_W-1:0] words [WORDS];
  logic [DATA_W-1:0] out_reg;
  logic wr_active;
  logic rise_seen;
  rsk_phase_t phase_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write: a level condition, so each sampled cycle under it rewrites the word.
  assign wr_active = (write_en_n_i == RSK_ACTIVE) && (chip_sel_n_i == RSK_ACTIVE)
                     && !clock_pulse_in_i;

  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++) begin : g_word
      rsk_word_cell #(.DATA_W(DATA_W)) u_cell (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wr_sel_i(wr_active && (word_addr_i == ADDR_W'(gi))),
        .write_data_i(write_data_i),
        .word_o(words[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin clock phase tracker; a rise is a LOW phase followed by a high sample.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_reg <= RSK_PH_HIGH;
    end else begin
      case (phase_reg)
        RSK_PH_LOW: if (clock_pulse_in_i) phase_reg <= RSK_PH_HIGH;
        RSK_PH_HIGH: if (!clock_pulse_in_i) phase_reg <= RSK_PH_LOW;
        default: phase_reg <= RSK_PH_HIGH;
      endcase
    end
  end

  assign rise_seen = (phase_reg == RSK_PH_LOW) && clock_pulse_in_i;

  // Reset starts in the high phase so that a pin held high at release is no rise.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_reg <= RSK_OUT_RST;
    end else if (rise_seen && (chip_sel_n_i == RSK_ACTIVE)) begin
      out_reg <= words[word_addr_i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign read_data_out_o = out_reg;
  assign read_data_out_oe_o = (out_en_n_i == RSK_ACTIVE) ? '1 : '0;

  ////////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] prev_word;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_word <= RSK_WORD_RST;
    end else begin
      prev_word <= words[word_addr_i];
    end
  end

  load_on_rise_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rise_seen && !chip_sel_n_i) |=> (out_reg == prev_word))
    else $error("output register missed the addressed word on a rise");
  hold_no_rise_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !rise_seen |=> $stable(out_reg))
    else $error("output register changed without a pin clock rise");
  hold_deselect_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    chip_sel_n_i |=> $stable(out_reg))
    else $error("output register changed while deselected");
  hold_on_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_active |=> $stable(out_reg))
    else $error("write disturbed the output register");
  write_store_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_active |=> (words[$past(word_addr_i)] == $past(write_data_i)))
    else $error("written word does not hold the data");
  write_track_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_active ##1 (wr_active && $stable(word_addr_i)))
    |=> (words[$past(word_addr_i)] == $past(write_data_i)))
    else $error("word did not follow data during a held write");
  no_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !wr_active |=> (prev_word == words[$past(word_addr_i)]))
    else $error("array changed without a write");
  rise_deselect_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rise_seen && chip_sel_n_i) |=> $stable(out_reg))
    else $error("deselected rise loaded the output register");
  phase_legal_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (phase_reg == RSK_PH_LOW) || (phase_reg == RSK_PH_HIGH))
    else $error("pin clock phase tracker left its legal states");
  float_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    out_en_n_i |-> (read_data_out_oe_o == '0))
    else $error("outputs driven while output enable is high");
  drive_on_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !out_en_n_i |-> (read_data_out_oe_o == '1 && read_data_out_o == out_reg))
    else $error("outputs not driving the output register");

  write_seen_c: cover property (@(posedge mclk_i) disable iff (rst_i) wr_active);
  read_seen_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    rise_seen && !chip_sel_n_i);
  write_then_read_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    wr_active ##[1:4] (rise_seen && !chip_sel_n_i));
  deselect_rise_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    rise_seen && chip_sel_n_i);
  held_write_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    wr_active ##1 wr_active);
endmodule // rsk_register_stack
`default_nettype wire

// >>> verif/rsk_host_model.sv
// Host-side pin driver that turns bench commands into register stack strobes.
`timescale 1ns/1ps
`default_nettype none
module rsk_host_model (
  // Clock and command: 0 idle, 1 write, 2 clock low, 3 clock high
  input wire logic mclk_i,
  input wire logic [1:0] op_i,
  input wire logic [3:0] addr_i,
  input wire logic [3:0] data_i,
  // Host pins
  output logic pin_clk_o,
  output logic cs_n_o,
  output logic we_n_o,
  output logic [3:0] addr_o,
  output logic [3:0] data_o
);
  // Idle parks the pin clock high, so leaving a write gives a rise with chip select off.
  always_ff @(posedge mclk_i) begin
    cs_n_o <= (op_i == 2'h0);
    we_n_o <= (op_i != 2'h1);
    pin_clk_o <= (op_i == 2'h0) || (op_i == 2'h3);
    addr_o <= addr_i;
    data_o <= data_i;
  end
endmodule // rsk_host_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the register stack.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rsk_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic oen = 1'b0;
  logic [1:0] op = 2'h0;
  logic [3:0] addr = 4'h0, data = 4'h0, ha, hd, q, oe;
  logic pin_clk, cs_n, we_n;
  logic [3:0] ref_mem [16];
  int fail_count = 0, compares = 0, seed = 32'h7c4e27d8;
  always #5 mclk_i = ~mclk_i;
  rsk_host_model rsk_host_model_inst (.mclk_i(mclk_i), .op_i(op), .addr_i(addr),
    .data_i(data), .pin_clk_o(pin_clk), .cs_n_o(cs_n), .we_n_o(we_n), .addr_o(ha),
    .data_o(hd));
  rsk_register_stack rsk_register_stack_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .clock_pulse_in_i(pin_clk), .chip_sel_n_i(cs_n), .write_en_n_i(we_n), .out_en_n_i(oen),
    .word_addr_i(ha), .write_data_i(hd), .read_data_out_o(q), .read_data_out_oe_o(oe));
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input logic [1:0] o, input logic [3:0] a, input logic [3:0] d);
    @(posedge mclk_i);
    op <= o;
    addr <= a;
    data <= d;
  endtask
  // Four idle cycles cover the host pipeline stage plus the rise detection.
  task automatic rd(input logic [3:0] a);
    cyc(2'h2, a, 4'h0);
    cyc(2'h3, a, 4'h0);
    repeat (4) cyc(2'h0, a, 4'h0);
  endtask
  function automatic logic [3:0] oe_exp(input logic n);
    return {4{n == RSK_ACTIVE}};
  endfunction
  task summarize;
    $display("Checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    logic [3:0] a;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < RSK_WORDS; i++) begin
      ref_mem[i] = 4'($random(seed));
      cyc(2'h1, i[3:0], ref_mem[i]);
    end
    for (int i = 0; i < 24; i++) begin
      a = 4'($random(seed));
      oen <= 1'($random(seed));
      rd(a);
      chk(q, ref_mem[a], "read word");
      chk(oe, oe_exp(oen), "output enable");
    end
    $display("Test random reads done");
    oen <= RSK_ACTIVE;
    rd(4'h5);
    cyc(2'h1, 4'h5, 4'h3);
    cyc(2'h1, 4'h5, 4'ha);
    repeat (4) cyc(2'h0, 4'h5, 4'h0);
    chk(q, ref_mem[5], "held out");
    ref_mem[5] = 4'ha;
    rd(4'h5);
    chk(q, 4'ha, "tracked word");
    $display("Test write tracking done");
    repeat (3) cyc(2'h2, 4'h6, 4'h0);
    chk(q, 4'ha, "falling clock");
    rd(4'h6);
    chk(q, ref_mem[6], "no write word");
    $display("Test edge rules done");
    summarize();
  end
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
